/* hdl/spc_addr_dec.sv */
// Combinational card address decoder for the conflict guard
`timescale 1ns/1ps
module spc_addr_dec
    import spc_pkg::*;
#(
    parameter int unsigned RELOC_SPAN = 16    // Width of a relocation window
)(
    spc_dec_if.dec dec
);

    // ****************************************
    // Parameter check
    // ****************************************
    // Window must hold the eight task ports plus control pair
    if (RELOC_SPAN < 16 || RELOC_SPAN > 512)
    begin : g_bad_span
        $error("RELOC_SPAN out of range");
    end

    // ****************************************
    // Helpers
    // ****************************************
    // Inclusive range check, used for both task port ranges and the relocation window
    function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] lo,
                                      input logic [ADDR_W-1:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    logic pri_task;   // 1F0..1F7
    logic sec_task;   // 170..177
    logic win_hit;    // Relocation window

    assign pri_task = in_range(dec.addr, PRI_TASK_LO, PRI_TASK_HI);
    assign sec_task = in_range(dec.addr, SEC_TASK_LO, SEC_TASK_HI);
    assign win_hit  = in_range(dec.addr, dec.reloc_base,
                               dec.reloc_base + ADDR_W'(RELOC_SPAN - 1));

    // Shared port, flagged whatever the card placement
    assign dec.drv_addr = (dec.addr == PRI_DRVADR) || (dec.addr == SEC_DRVADR);

    // ****************************************
    // Card select
    // ****************************************
    // Relocation beats placement; byte-granular decode drops the shared port
    always_comb
    begin
        if (dec.reloc_en)
        begin
            dec.hit = win_hit;
        end
        else if (dec.secondary)
        begin
            dec.hit = sec_task || (dec.addr == SEC_CTRL) ||
                      (!dec.byte_gran && dec.addr == SEC_DRVADR);
        end
        else
        begin
            dec.hit = pri_task || (dec.addr == PRI_CTRL) ||
                      (!dec.byte_gran && dec.addr == PRI_DRVADR);
        end
    end

endmodule

/* hdl/spc_dec_if.sv */
// Bundle between the guard top and its address decoder
`timescale 1ns/1ps
interface spc_dec_if;
    import spc_pkg::*;

    logic [ADDR_W-1:0] addr;        // Synchronised host I/O address
    logic              byte_gran;   // Byte-granular decode selected
    logic              secondary;   // Card placed at secondary set
    logic              reloc_en;    // Card relocated to a free window
    logic [ADDR_W-1:0] reloc_base;  // Base of relocation window
    logic              hit;         // Address belongs to the card
    logic              drv_addr;    // Address is a shared drive-address port

    modport top (output addr, byte_gran, secondary, reloc_en, reloc_base,
                 input  hit, drv_addr);
    modport dec (input  addr, byte_gran, secondary, reloc_en, reloc_base,
                 output hit, drv_addr);
endinterface

/* hdl/spc_guard.sv */
// Socket guard: card enable decode and data line steering for ports 3F7/377
`timescale 1ns/1ps

// Functional notes
// - Primary byte decode: 1F0-1F7, 3F6 only
// - Secondary byte decode: 170-177, 376 only
// - Option floats data bit 7 on 3F7/377
// - Same accesses mask card 16-bit indication
// - Floppy option floats bits 6-0, masks indication
// - Prefer card configuration ignoring shared port
// - Card may move to secondary or window
module spc_guard
    import spc_pkg::*;
#(
    parameter int unsigned RELOC_SPAN = 16    // Relocation window size in ports
)(
    // Clock and reset
    input  wire logic                      clk_sys_i,
    input  wire logic                      rst_i,
    // Host I/O cycle pins
    input  wire logic [spc_pkg::ADDR_W-1:0] host_addr_i,
    input  wire logic                      host_ior_n_i,
    input  wire logic                      host_iow_n_i,
    // Host data byte, three-signal form
    output logic      [spc_pkg::DATA_W-1:0] host_data_o,
    output logic      [spc_pkg::DATA_W-1:0] host_data_oe_n_o,
    output logic                           host_io16_n_o,
    // Card side pins
    input  wire logic [spc_pkg::DATA_W-1:0] card_data_i,
    input  wire logic                      card_io_width16_indication_n_i,
    output logic                           card_enable_o,
    // Socket configuration, from host-side logic on this clock
    input  wire logic                      cfg_byte_gran_i,
    input  wire logic                      cfg_secondary_i,
    input  wire logic                      cfg_reloc_en_i,
    input  wire logic [spc_pkg::ADDR_W-1:0] cfg_reloc_base_i,
    input  wire logic                      cfg_force_d7_i,
    input  wire logic                      cfg_force_d60_i
);
    import spc_pkg::*;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [ADDR_W-1:0] addr_s1_reg;    // First stage, read only by second
    logic [ADDR_W-1:0] addr_s2_reg;    // Usable address
    logic              ior_s1_reg;     // Read strobe stage 1
    logic              ior_s2_reg;     // Read strobe stage 2
    logic              iow_s1_reg;     // Write strobe stage 1
    logic              iow_s2_reg;     // Write strobe stage 2
    logic [DATA_W-1:0] cdat_s1_reg;    // Card data stage 1
    logic [DATA_W-1:0] cdat_s2_reg;    // Card data stage 2
    logic              c16_s1_reg;     // Card width indication stage 1
    logic              c16_s2_reg;     // Card width indication stage 2

    // Strobes reset idle so no phantom access follows reset
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            addr_s1_reg <= '0;
            addr_s2_reg <= '0;
            ior_s1_reg  <= 1'b1;
            ior_s2_reg  <= 1'b1;
            iow_s1_reg  <= 1'b1;
            iow_s2_reg  <= 1'b1;
            cdat_s1_reg <= '0;
            cdat_s2_reg <= '0;
            c16_s1_reg  <= 1'b1;
            c16_s2_reg  <= 1'b1;
        end
        else
        begin
            addr_s1_reg <= host_addr_i;
            addr_s2_reg <= addr_s1_reg;
            ior_s1_reg  <= host_ior_n_i;
            ior_s2_reg  <= ior_s1_reg;
            iow_s1_reg  <= host_iow_n_i;
            iow_s2_reg  <= iow_s1_reg;
            cdat_s1_reg <= card_data_i;
            cdat_s2_reg <= cdat_s1_reg;
            c16_s1_reg  <= card_io_width16_indication_n_i;
            c16_s2_reg  <= c16_s1_reg;
        end
    end

    // ****************************************
    // Force mode controls
    // ****************************************
    logic force_d7_reg;     // Bit 7 floated on shared port (ATA card)
    logic force_d60_reg;    // Bits 6-0 floated on shared port (floppy card)

    // Cleared by reset, then follow the socket configuration
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            force_d7_reg  <= 1'b0;
            force_d60_reg <= 1'b0;
        end
        else
        begin
            force_d7_reg  <= cfg_force_d7_i;
            force_d60_reg <= cfg_force_d60_i;
        end
    end

    // ****************************************
    // Address decode
    // ****************************************
    spc_dec_if dbus ();

    // Card placement choice, including a card mode that ignores 3F7/377,
    // is host policy; this logic only honours what it is given
    assign dbus.addr       = addr_s2_reg;
    assign dbus.byte_gran  = cfg_byte_gran_i;
    assign dbus.secondary  = cfg_secondary_i;
    assign dbus.reloc_en   = cfg_reloc_en_i;
    assign dbus.reloc_base = cfg_reloc_base_i;

    spc_addr_dec #(
        .RELOC_SPAN (RELOC_SPAN)
    ) u_dec (
        .dec (dbus.dec)
    );

    logic io_rd;        // Host read cycle in progress
    logic io_acc;       // Any host I/O cycle in progress
    logic shr_acc;      // Cycle targets 3F7 or 377
    logic mask_16;      // Width indication suppressed this cycle

    assign io_rd   = !ior_s2_reg;
    assign io_acc  = !ior_s2_reg || !iow_s2_reg;
    assign shr_acc = io_acc && dbus.drv_addr;
    assign mask_16 = shr_acc && (force_d7_reg || force_d60_reg);

    // ****************************************
    // Card enable and width indication
    // ****************************************
    logic card_en_reg;  // Card enable towards the socket
    logic io16_n_reg;   // Host 16-bit indication, active low

    // One cycle behind the synchronised strobes
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            card_en_reg <= 1'b0;
            io16_n_reg  <= 1'b1;
        end
        else
        begin
            card_en_reg <= io_acc && dbus.hit;
            // Masked indication reads as negated on the host side
            io16_n_reg  <= !(io_acc && dbus.hit && !c16_s2_reg && !mask_16);
        end
    end

    // ****************************************
    // Data steering
    // ****************************************
    logic [DATA_W-1:0] hdat_reg;   // Byte presented to the host
    logic [DATA_W-1:0] oe_n_reg;   // Per-line enable, low drives

    // A plain transceiver would always drive; the other bus party drives
    // its half of the byte on the shared port, so we float ours
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            hdat_reg <= '0;
            oe_n_reg <= OE_N_RST;
        end
        else
        begin
            hdat_reg <= cdat_s2_reg;
            if (io_rd && dbus.hit)
            begin
                oe_n_reg[7]   <= shr_acc && force_d7_reg;
                oe_n_reg[6:0] <= {7{shr_acc && force_d60_reg}};
            end
            else
            begin
                oe_n_reg <= OE_N_RST;
            end
        end
    end

    assign host_data_o      = hdat_reg;
    assign host_data_oe_n_o = oe_n_reg;
    assign host_io16_n_o    = io16_n_reg;
    assign card_enable_o    = card_en_reg;

    // ****************************************
    // Checks
    // ****************************************
    a_pri_no_drvadr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (io_acc && cfg_byte_gran_i && !cfg_secondary_i && !cfg_reloc_en_i
         && addr_s2_reg == PRI_DRVADR) |=> !card_enable_o)
        else $error("card enabled on primary 3F7");

    a_pri_ctrl_en: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (io_acc && !cfg_secondary_i && !cfg_reloc_en_i
         && addr_s2_reg == PRI_CTRL) |=> card_enable_o)
        else $error("card not enabled on 3F6");

    a_sec_no_drvadr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (io_acc && cfg_byte_gran_i && cfg_secondary_i && !cfg_reloc_en_i
         && addr_s2_reg == SEC_DRVADR) |=> !card_enable_o)
        else $error("card enabled on secondary 377");

    a_d7_float: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (io_rd && dbus.hit && dbus.drv_addr && force_d7_reg)
        |=> host_data_oe_n_o[7])
        else $error("bit 7 driven on shared port");

    a_io16_mask: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (shr_acc && force_d7_reg) |=> host_io16_n_o)
        else $error("width indication passed on shared port");

    a_d60_float: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (io_rd && dbus.hit && dbus.drv_addr && force_d60_reg && !force_d7_reg)
        |=> (host_data_oe_n_o == 8'h7F) && host_io16_n_o)
        else $error("low bits not floated on shared port");

    a_reloc_only: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (io_acc && cfg_reloc_en_i && (addr_s2_reg < cfg_reloc_base_i))
        |=> !card_enable_o)
        else $error("card enabled below relocation window");

    a_force_reset: assert property (@(posedge clk_sys_i)
        $fell(rst_i) |-> !force_d7_reg && !force_d60_reg
        && host_data_oe_n_o == 8'hFF)
        else $error("forcing active after reset");

    a_idle_float: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !io_rd |=> host_data_oe_n_o == 8'hFF)
        else $error("host data driven outside a read");

endmodule

/* hdl/spc_pkg.sv */
// Shared constants for the socket port conflict guard
package spc_pkg;

    // ****************************************
    // Address bus geometry
    // ****************************************
    localparam int unsigned ADDR_W = 10;    // ISA-style 10-bit I/O decode
    localparam int unsigned DATA_W = 8;     // Low data byte steered by the guard

    // ****************************************
    // Primary port set
    // ****************************************
    localparam logic [ADDR_W-1:0] PRI_TASK_LO = 10'h1F0;
    localparam logic [ADDR_W-1:0] PRI_TASK_HI = 10'h1F7;
    localparam logic [ADDR_W-1:0] PRI_CTRL    = 10'h3F6;
    localparam logic [ADDR_W-1:0] PRI_DRVADR  = 10'h3F7;

    // ****************************************
    // Secondary port set
    // ****************************************
    localparam logic [ADDR_W-1:0] SEC_TASK_LO = 10'h170;
    localparam logic [ADDR_W-1:0] SEC_TASK_HI = 10'h177;
    localparam logic [ADDR_W-1:0] SEC_CTRL    = 10'h376;
    localparam logic [ADDR_W-1:0] SEC_DRVADR  = 10'h377;

    // ****************************************
    // Reset values and timing
    // ****************************************
    localparam logic [DATA_W-1:0] OE_N_RST    = 8'hFF;  // All lines floated
    localparam int unsigned       SYNC_STAGES = 2;      // Pin synchroniser depth

endpackage

/* sim/socket_port_conflict_guard_tb.sv */
// Self-checking bench for the socket port conflict guard
`timescale 1ns/1ps
module socket_port_conflict_guard_tb;
    import spc_pkg::*;

    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic [ADDR_W-1:0] addr = 10'h000;
    logic              ior_n = 1'b1;
    logic              iow_n = 1'b1;
    logic              bgran = 1'b0;
    logic              sec = 1'b0;
    logic              reloc = 1'b0;
    logic [ADDR_W-1:0] rbase = 10'h000;
    logic              f7 = 1'b0;
    logic              f60 = 1'b0;
    logic [DATA_W-1:0] hdata;
    logic [DATA_W-1:0] oe_n;
    logic              io16_n;
    logic [DATA_W-1:0] cdata;
    logic              cio16_n;
    logic              cen;
    int                num_errors = 0;
    int                cmp_count = 0;

    always #4 clk = ~clk;

    spc_guard dut (.clk_sys_i(clk), .rst_i(rst), .host_addr_i(addr),
        .host_ior_n_i(ior_n), .host_iow_n_i(iow_n), .host_data_o(hdata),
        .host_data_oe_n_o(oe_n), .host_io16_n_o(io16_n), .card_data_i(cdata),
        .card_io_width16_indication_n_i(cio16_n), .card_enable_o(cen),
        .cfg_byte_gran_i(bgran), .cfg_secondary_i(sec), .cfg_reloc_en_i(reloc),
        .cfg_reloc_base_i(rbase), .cfg_force_d7_i(f7), .cfg_force_d60_i(f60));

    spc_card_model card (.clk_sys_i(clk), .card_enable_i(cen),
        .rd_value_i(8'hA5), .card_data_o(cdata), .io16_n_o(cio16_n));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One host cycle, checked while held and again after release
    task automatic io_cycle(input logic [ADDR_W-1:0] a, input logic wr,
                            input logic en, input logic [7:0] oe, input logic i16);
        @(negedge clk);
        addr = a;
        repeat (3) @(negedge clk);
        ior_n = wr;
        iow_n = ~wr;
        repeat (8) @(negedge clk);
        check({7'h00, cen}, {7'h00, en});
        check(oe_n, oe);
        check({7'h00, io16_n}, {7'h00, i16});
        if (!wr && en)
            check(hdata, 8'hA5);
        ior_n = 1'b1;
        iow_n = 1'b1;
        repeat (5) @(negedge clk);
        check({7'h00, cen}, 8'h00);
        check(oe_n, OE_N_RST);
    endtask

    task automatic print_verdict();
        if (num_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        check({7'h00, cen}, 8'h00);
        check(oe_n, OE_N_RST);
        check({7'h00, io16_n}, 8'h01);
    endtask

    task automatic t_primary();
        logic [ADDR_W-1:0] hits[9] = '{10'h1F0, 10'h1F1, 10'h1F2, 10'h1F3,
                                       10'h1F4, 10'h1F5, 10'h1F6, 10'h1F7, 10'h3F6};
        bgran = 1'b1;
        sec = 1'b0;
        foreach (hits[i])
            io_cycle(hits[i], 1'b0, 1'b1, 8'h00, 1'b0);
        io_cycle(10'h3F7, 1'b0, 1'b0, 8'hFF, 1'b1);
        io_cycle(10'h1F8, 1'b0, 1'b0, 8'hFF, 1'b1);
        io_cycle(10'h1F0, 1'b1, 1'b1, 8'hFF, 1'b0);
    endtask

    task automatic t_secondary();
        logic [ADDR_W-1:0] hits[9] = '{10'h170, 10'h171, 10'h172, 10'h173,
                                       10'h174, 10'h175, 10'h176, 10'h177, 10'h376};
        bgran = 1'b1;
        sec = 1'b1;
        foreach (hits[i])
            io_cycle(hits[i], 1'b0, 1'b1, 8'h00, 1'b0);
        io_cycle(10'h377, 1'b0, 1'b0, 8'hFF, 1'b1);
        io_cycle(10'h1F0, 1'b0, 1'b0, 8'hFF, 1'b1);
    endtask

    // Each force mode on the shared port, both placements
    task automatic t_force();
        logic [7:0] exp[4] = '{8'h00, 8'h80, 8'h7F, 8'hFF};
        bgran = 1'b0;
        for (int m = 0; m < 4; m++)
        begin
            f7 = m[0];
            f60 = m[1];
            sec = 1'b0;
            io_cycle(10'h3F7, 1'b0, 1'b1, exp[m], (m == 0) ? 1'b0 : 1'b1);
            sec = 1'b1;
            io_cycle(10'h377, 1'b0, 1'b1, exp[m], (m == 0) ? 1'b0 : 1'b1);
        end
        sec = 1'b0;
        io_cycle(10'h1F0, 1'b0, 1'b1, 8'h00, 1'b0);
        f7 = 1'b0;
        f60 = 1'b0;
    endtask

    task automatic t_reloc();
        reloc = 1'b1;
        rbase = 10'h300;
        io_cycle(10'h300, 1'b0, 1'b1, 8'h00, 1'b0);
        io_cycle(10'h30F, 1'b0, 1'b1, 8'h00, 1'b0);
        io_cycle(10'h310, 1'b0, 1'b0, 8'hFF, 1'b1);
        io_cycle(10'h2FF, 1'b0, 1'b0, 8'hFF, 1'b1);
        reloc = 1'b0;
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial
    begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_reset();
        t_primary();
        t_secondary();
        t_force();
        t_reloc();
        print_verdict();
    end

    // Cut a hang short
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        print_verdict();
    end
endmodule

/* sim/spc_card_model.sv */
// Behavioural model of the card that sits in the socket
`timescale 1ns/1ps
module spc_card_model
    import spc_pkg::*;
(
    // Clock
    input  wire logic                       clk_sys_i,
    // Socket side
    input  wire logic                       card_enable_i,
    input  wire logic [spc_pkg::DATA_W-1:0] rd_value_i,
    output logic      [spc_pkg::DATA_W-1:0] card_data_o,
    output logic                            io16_n_o
);
    import spc_pkg::*;

    // ****************************************
    // Card answer
    // ****************************************
    logic [DATA_W-1:0] last_reg = 8'h00;    // Last byte driven while selected

    // Outputs settle at the first edge, while the guard is still held in reset

    // Drive the read value while selected; released lines carry its complement, not the old byte
    always @(posedge clk_sys_i)
    begin
        if (card_enable_i)
        begin
            card_data_o <= rd_value_i;
            last_reg    <= rd_value_i;
            io16_n_o    <= 1'b0;            // Card claims a 16-bit port
        end
        else
        begin
            card_data_o <= ~last_reg;
            io16_n_o    <= 1'b1;
        end
    end
endmodule
